// >>> logic/fmsp_consts.vh
// constants of the four-mode serial port: offsets, fields, resets, counts
`ifndef FMSP_CONSTS_VH
`define FMSP_CONSTS_VH
// register offsets on the plain register port
`define FMSP_OFS_BUF      3'h0
`define FMSP_OFS_CTL      3'h1
`define FMSP_OFS_STAT     3'h2
`define FMSP_OFS_MASK     3'h3
`define FMSP_OFS_RATE     3'h4
// serial_control_reg fields
`define FMSP_CTL_MODE_HI  7
`define FMSP_CTL_MODE_LO  6
`define FMSP_CTL_FILT     5
`define FMSP_CTL_REN      4
`define FMSP_CTL_TX9      3
`define FMSP_CTL_RX9      2
// status, mask and rate fields
`define FMSP_ST_RXD       0
`define FMSP_ST_TXD       1
`define FMSP_ST_OVR       2
`define FMSP_RATE_FAST    0
// modes
`define FMSP_MODE_SHIFT   2'h0
`define FMSP_MODE_ASYNC10 2'h1
`define FMSP_MODE_FIXED11 2'h2
`define FMSP_MODE_VAR11   2'h3
// reset values
`define FMSP_CTL_RST      5'h00
`define FMSP_MASK_RST     3'h0
`define FMSP_STAT_RST     3'h0
`define FMSP_RATE_RST     1'h0
// mode 0 shift clock: one bit per 12 system clocks
`define FMSP_M0_DIV       4'hC
`define FMSP_M0_HALF      4'h6
`define FMSP_M0_BITS      4'h8
// async oversampling: 16 ticks per bit, sample at tick 8
`define FMSP_OVS_LAST     4'hF
`define FMSP_OVS_MID      4'h7
// fixed-rate mode 2 prescale: osc/32 -> 2 clocks, osc/64 -> 4 clocks
`define FMSP_PRE_FAST     2'h1
`define FMSP_PRE_SLOW     2'h3
// frame lengths in bits
`define FMSP_BITS_10      4'hA
`define FMSP_BITS_11      4'hB
// async receiver states
`define FMSP_RX_IDLE      2'h0
`define FMSP_RX_START     2'h1
`define FMSP_RX_DATA      2'h2
`endif

// >>> logic/fmsp_serial_port.v
// four-mode serial port: register port, shift-clock engine, async tx and rx
// Behaviour
// RL1 - separate transmit and receive engines run together
// RL2 - async receiving continues while previous byte unread
// RL3 - one buffer address: write tx, read rx
// RL4 - mode 0 data on rxd, clock on txd
// RL5 - mode 0 shifts at clock over twelve
// RL6 - mode 1 frame: start, 8 data, stop
// RL7 - mode 1 stop bit into rx_ninth_bit
// RL8 - mode 2 frame carries tx_ninth_bit as ninth
// RL9 - mode 2 stores ninth bit, stop ignored
// RL10 - mode 2 rate osc/32 or osc/64
// RL11 - mode 3 like mode 2, external rate
// RL12 - buffer write starts transmission every mode
// RL13 - mode 0 receives when enabled, flag clear
// RL14 - async receive starts on start bit, enabled
// RL15 - modes 2,3 filter passes only ninth bit one
// RL16 - done flags sticky until software clears
// RL17 - modes 1,3 oversample the external baud tick
`include "fmsp_consts.vh"

module fmsp_serial_port (
	// clock and reset
	input  wire       clk_sys_in,
	input  wire       reset_n_in,
	// register port
	input  wire [2:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	output reg  [7:0] reg_rdata_out,
	// serial pins
	input  wire       rxd_in,
	output wire       rxd_out,
	output wire       rxd_oe_out,
	output wire       txd_out,
	// external baud tick, sixteen per bit
	input  wire       baud_tick_in,
	// interrupt
	output wire       irq_out
);

	// synchronisers and edge memory
	reg        rxd_s1_q;
	reg        rxd_s2_q;
	reg        bd_s1_q;
	reg        bd_s2_q;
	reg        bd_s3_q;
	// software registers
	reg  [7:3] ctl_q;
	reg  [2:0] stat_q;
	reg  [2:0] mask_q;
	reg        fast_q;
	reg        rx9_q;
	reg  [7:0] rx_buf_q;
	// rate prescaler
	reg  [1:0] pre_q;
	// async transmitter
	reg        tx_busy_q;
	reg [10:0] tx_sh_q;
	reg  [3:0] tx_left_q;
	reg  [3:0] tx_sub_q;
	// mode 0 shift engine
	reg        m0_busy_q;
	reg        m0_rx_q;
	reg  [7:0] m0_sh_q;
	reg  [3:0] m0_bits_q;
	reg  [3:0] m0_div_q;
	// async receiver
	reg  [1:0] rx_st_q;
	reg  [3:0] rx_sub_q;
	reg  [3:0] rx_left_q;
	reg  [9:0] rx_sh_q;

	// decoded mode and strobes, engine events, receive datapath
	wire [1:0] mode;
	wire       mode0;
	wire       mode1;
	wire       wr_buf;
	wire       wr_ctl;
	wire       wr_stat;
	wire       tick16;
	wire       m0_start_rx;
	wire       m0_step;
	wire       m0_end;
	wire       m0_clk;
	wire       tx_step;
	wire       tx_end;
	wire       rx_step;
	wire       rx_end;
	wire [9:0] rx_nxt;
	wire [7:0] rx_data;
	wire       rx_ninth;
	wire       rx_pass;
	wire       rx_load;
	wire       rx_ovr;
	wire [2:0] stat_set;
	wire [2:0] stat_clr;

	// mode and strobe decode
	assign mode    = ctl_q[`FMSP_CTL_MODE_HI:`FMSP_CTL_MODE_LO];
	assign mode0   = (mode == `FMSP_MODE_SHIFT);
	assign mode1   = (mode == `FMSP_MODE_ASYNC10);
	assign wr_buf  = reg_wr_in && (reg_addr_in == `FMSP_OFS_BUF);
	assign wr_ctl  = reg_wr_in && (reg_addr_in == `FMSP_OFS_CTL);
	assign wr_stat = reg_wr_in && (reg_addr_in == `FMSP_OFS_STAT);

	// pin synchronisers, second stage feeds logic
	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			bd_s1_q  <= 1'b0;
			bd_s2_q  <= 1'b0;
			bd_s3_q  <= 1'b0;
		end
		else
		begin
			rxd_s1_q <= rxd_in;
			rxd_s2_q <= rxd_s1_q;
			bd_s1_q  <= baud_tick_in;
			bd_s2_q  <= bd_s1_q;
			bd_s3_q  <= bd_s2_q;
		end
	end

	// oversample tick: prescaled clock in mode 2, baud edges otherwise
	assign tick16 = (mode == `FMSP_MODE_FIXED11) ? (pre_q == 2'h0) // RL10
		: (bd_s2_q && !bd_s3_q); // RL17 RL11

	// prescaler for the fixed mode 2 rate
	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			pre_q <= 2'h0;
		else if (pre_q >= (fast_q ? `FMSP_PRE_FAST : `FMSP_PRE_SLOW))
			pre_q <= 2'h0; // RL10
		else
			pre_q <= pre_q + 2'h1;
	end

	// mode 0 engine: twelve clocks per bit, clock low then high
	assign m0_start_rx = mode0 && ctl_q[`FMSP_CTL_REN] && !stat_q[`FMSP_ST_RXD]
		&& !m0_busy_q && !wr_buf; // RL13
	assign m0_step = m0_busy_q && (m0_div_q == (`FMSP_M0_DIV - 4'h1)); // RL5
	assign m0_end  = m0_step && (m0_bits_q == (`FMSP_M0_BITS - 4'h1));
	// shift clock idles high, low over the first half of each bit
	assign m0_clk  = !m0_busy_q || (m0_div_q >= `FMSP_M0_HALF);

	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			m0_busy_q <= 1'b0;
			m0_rx_q   <= 1'b0;
			m0_sh_q   <= 8'h00;
			m0_bits_q <= 4'h0;
			m0_div_q  <= 4'h0;
		end
		else if (mode0 && wr_buf)
		begin
			m0_busy_q <= 1'b1; // RL12
			m0_rx_q   <= 1'b0;
			m0_sh_q   <= reg_wdata_in;
			m0_bits_q <= 4'h0;
			m0_div_q  <= 4'h0;
		end
		else if (m0_start_rx)
		begin
			m0_busy_q <= 1'b1;
			m0_rx_q   <= 1'b1;
			m0_bits_q <= 4'h0;
			m0_div_q  <= 4'h0;
		end
		else if (m0_busy_q)
		begin
			if (m0_step)
			begin
				m0_div_q  <= 4'h0;
				m0_bits_q <= m0_bits_q + 4'h1;
				// lsb first both ways, rx sampled at the end of the high half
				m0_sh_q   <= {m0_rx_q ? rxd_s2_q : 1'b1, m0_sh_q[7:1]}; // RL4
				if (m0_end)
					m0_busy_q <= 1'b0;
			end
			else
				m0_div_q <= m0_div_q + 4'h1;
		end
	end

	// async transmitter, 16 ticks per bit
	assign tx_step = tx_busy_q && tick16 && (tx_sub_q == `FMSP_OVS_LAST);
	assign tx_end  = tx_step && (tx_left_q == 4'h1);

	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			tx_busy_q <= 1'b0;
			tx_sh_q   <= 11'h7FF;
			tx_left_q <= 4'h0;
			tx_sub_q  <= 4'h0;
		end
		else if (!mode0 && wr_buf)
		begin
			tx_busy_q <= 1'b1; // RL12
			tx_sub_q  <= 4'h0;
			// start 0, data lsb first, ninth or stop, stop
			tx_sh_q   <= {1'b1, mode1 ? 1'b1 : ctl_q[`FMSP_CTL_TX9],
				reg_wdata_in, 1'b0}; // RL6 RL8
			tx_left_q <= mode1 ? `FMSP_BITS_10 : `FMSP_BITS_11; // RL11
		end
		else if (tx_busy_q && tick16)
		begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_step)
			begin
				// next bit out, idle ones refill from the top
				tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_end)
					tx_busy_q <= 1'b0;
			end
		end
	end

	// async receiver: mid-bit sampling from the start edge
	assign rx_step  = (rx_st_q == `FMSP_RX_DATA) && tick16
		&& (rx_sub_q == `FMSP_OVS_LAST);
	assign rx_end   = rx_step && (rx_left_q == 4'h1);
	assign rx_nxt   = {rxd_s2_q, rx_sh_q[9:1]};
	// mode 1 keeps the stop bit as ninth, modes 2,3 drop the stop
	assign rx_data  = mode1 ? rx_nxt[8:1] : rx_nxt[7:0];
	assign rx_ninth = mode1 ? rx_nxt[9] : rx_nxt[8]; // RL7 RL9
	assign rx_pass  = mode1 || !ctl_q[`FMSP_CTL_FILT] || rx_ninth; // RL15
	// second byte lost when the first is still unread
	assign rx_load  = (rx_end && rx_pass && !stat_q[`FMSP_ST_RXD])
		|| (m0_end && m0_rx_q); // RL2
	assign rx_ovr   = rx_end && rx_pass && stat_q[`FMSP_ST_RXD]; // RL2

	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rx_st_q   <= `FMSP_RX_IDLE;
			rx_sub_q  <= 4'h0;
			rx_left_q <= 4'h0;
			rx_sh_q   <= 10'h000;
		end
		else
		begin
			case (rx_st_q)
			`FMSP_RX_IDLE:
			begin
				rx_sub_q <= 4'h0;
				if (!mode0 && ctl_q[`FMSP_CTL_REN] && !rxd_s2_q)
					rx_st_q <= `FMSP_RX_START; // RL14
			end
			`FMSP_RX_START:
			begin
				// half a bit on, the start bit must still be low
				if (tick16)
				begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rx_sub_q == `FMSP_OVS_MID)
					begin
						rx_sub_q  <= 4'h0;
						rx_left_q <= (mode1 ? `FMSP_BITS_10 : `FMSP_BITS_11)
							- 4'h1;
						// glitch shorter than half a bit is rejected
						rx_st_q   <= rxd_s2_q ? `FMSP_RX_IDLE : `FMSP_RX_DATA;
					end
				end
			end
			`FMSP_RX_DATA:
			begin
				// one sample per sixteen ticks, at mid-bit
				if (tick16)
					rx_sub_q <= rx_sub_q + 4'h1;
				if (rx_step)
				begin
					rx_sh_q   <= rx_nxt;
					rx_left_q <= rx_left_q - 4'h1;
					if (rx_end)
						rx_st_q <= `FMSP_RX_IDLE;
				end
			end
			default:
				rx_st_q <= `FMSP_RX_IDLE;
			endcase
		end
	end

	// receive register, separate from the transmit shifter
	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rx_buf_q <= 8'h00;
			rx9_q    <= 1'b0;
		end
		else if (rx_load)
		begin
			rx_buf_q <= (m0_end && m0_rx_q) ? {rxd_s2_q, m0_sh_q[7:1]}
				: rx_data; // RL3
			// shift mode frames carry no ninth bit
			if (!(m0_end && m0_rx_q))
				rx9_q <= rx_ninth; // RL7 RL9
		end
	end

	// sticky events, set beats a same-cycle clear
	assign stat_set = {rx_ovr, tx_end || (m0_end && !m0_rx_q), rx_load};
	assign stat_clr = wr_stat ? reg_wdata_in[2:0] : 3'h0;

	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			stat_q <= `FMSP_STAT_RST;
		else
			stat_q <= (stat_q & ~stat_clr) | stat_set; // RL16
	end

	// control, mask and rate registers
	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ctl_q  <= `FMSP_CTL_RST;
			mask_q <= `FMSP_MASK_RST;
			fast_q <= `FMSP_RATE_RST;
		end
		else
		begin
			if (wr_ctl)
				ctl_q <= reg_wdata_in[7:3];
			if (reg_wr_in && (reg_addr_in == `FMSP_OFS_MASK))
				mask_q <= reg_wdata_in[2:0];
			if (reg_wr_in && (reg_addr_in == `FMSP_OFS_RATE))
				fast_q <= reg_wdata_in[`FMSP_RATE_FAST];
		end
	end

	// read data one cycle after the read strobe, zero otherwise
	always @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
			`FMSP_OFS_BUF:  reg_rdata_out <= rx_buf_q; // RL3
			`FMSP_OFS_CTL:  reg_rdata_out <= {ctl_q, rx9_q, stat_q[1:0]};
			`FMSP_OFS_STAT: reg_rdata_out <= {5'h00, stat_q};
			`FMSP_OFS_MASK: reg_rdata_out <= {5'h00, mask_q};
			`FMSP_OFS_RATE: reg_rdata_out <= {7'h00, fast_q};
			default:        reg_rdata_out <= 8'h00;
			endcase
		end
		else
			reg_rdata_out <= 8'h00;
	end

	// pins: mode 0 drives data on rxd and clock on txd
	assign rxd_out    = m0_sh_q[0]; // RL4
	assign rxd_oe_out = mode0 && m0_busy_q && !m0_rx_q;
	assign txd_out    = mode0 ? m0_clk : tx_sh_q[0]; // RL1

	// level interrupt while an unmasked event stands
	assign irq_out    = |(stat_q & mask_q);

endmodule // fmsp_serial_port

// >>> test/fmsp_serial_port_asserts.sv
// assertion checker on the pins and register port of the serial port
`include "fmsp_consts.vh"
module fmsp_serial_port_asserts (
	// clock and reset
	input wire logic       clk_sys_in,
	input wire logic       reset_n_in,
	// register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// serial pins and interrupt
	input wire logic       rxd_out,
	input wire logic       rxd_oe_out,
	input wire logic       txd_out,
	input wire logic       irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	logic [7:0] oe_cnt_q;
	logic [1:0] mode_q;
	// mode shadowed from control writes, tells async frames from shift clocks
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
			mode_q <= `FMSP_MODE_SHIFT;
		else if (reg_wr_in && reg_addr_in == `FMSP_OFS_CTL)
			mode_q <= reg_wdata_in[`FMSP_CTL_MODE_HI:`FMSP_CTL_MODE_LO];
	// cycles the shift mode has driven the data pin
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
			oe_cnt_q <= 8'h00;
		else
			oe_cnt_q <= rxd_oe_out ? oe_cnt_q + 8'h01 : 8'h00;
	// one shift clock bit: six low then high, six high
	sequence s_low6; !txd_out [*6] ##1 txd_out; endsequence
	sequence s_high6; txd_out [*6]; endsequence
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data not zero outside answer cycle");
	a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 3'h4 |=>
		reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	a_shift_low: assert property ($fell(txd_out) && rxd_oe_out |-> s_low6)
		else $error("shift clock low half wrong");
	a_shift_high: assert property ($rose(txd_out) && rxd_oe_out |-> s_high6)
		else $error("shift clock high half wrong");
	a_shift_data: assert property (rxd_oe_out && $past(rxd_oe_out) && !$fell(txd_out)
		|-> $stable(rxd_out)) else $error("shift data moved off clock fall");
	a_shift_len: assert property ($fell(rxd_oe_out) |-> oe_cnt_q == 8'h60)
		else $error("shift frame not 96 clocks");
	a_async_bit: assert property ($fell(txd_out) && mode_q != `FMSP_MODE_SHIFT
		|-> !txd_out [*8]) else $error("async low bit too short");
	a_mask_off: assert property (reg_wr_in && reg_addr_in == `FMSP_OFS_MASK &&
		reg_wdata_in[2:0] == 3'h0 |=> !irq_out) else $error("irq high with mask clear");
endmodule // fmsp_serial_port_asserts
bind fmsp_serial_port fmsp_serial_port_asserts u_chk (.clk_sys_in, .reset_n_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.rxd_out, .rxd_oe_out, .txd_out, .irq_out);

// >>> test/fmsp_peer.sv
// serial peer: sends frames on the receive line, captures transmit frames
module fmsp_peer (
	// clock
	input  wire logic clk_in,
	// serial lines
	output logic      rxd_line_out,
	input  wire logic txd_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rxd_line_out = 1'b1;
	// eleven bits lsb first, start bit first, line idles high after
	task automatic send(input int per, input logic [10:0] f);
		for (int i = 0; i < 11; i++)
		begin
			rxd_line_out <= f[i];
			repeat (per) @(posedge clk_in);
		end
		rxd_line_out <= 1'b1;
	endtask
	// sample eleven bit centres after the start edge
	task automatic get(input int per, output logic [10:0] f);
		@(negedge txd_in);
		repeat (per / 2) @(posedge clk_in);
		for (int i = 0; i < 11; i++)
		begin
			f[i] = txd_in;
			repeat (per) @(posedge clk_in);
		end
	endtask
	// shift mode: a bit per falling shift clock, lsb first, held past last sample
	task automatic shift_out(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge txd_in);
			rxd_line_out <= v[i];
		end
		@(posedge txd_in);
		repeat (12) @(posedge clk_in);
		rxd_line_out <= 1'b1;
	endtask
endmodule // fmsp_peer

// >>> test/fmsp_tb.sv
// self-checking bench for the four-mode serial port
`include "fmsp_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys_in   = 1'b0;
	logic       reset_n_in   = 1'b0;
	logic [2:0] reg_addr_in  = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic       reg_wr_in    = 1'b0;
	logic       reg_rd_in    = 1'b0;
	logic       baud_tick_in = 1'b0;
	logic [7:0] d;
	logic [7:0] b;
	logic [10:0] f;
	wire  [7:0] reg_rdata_out;
	wire        rxd_out, rxd_oe_out, txd_out, irq_out, peer_rxd;
	wire        rxd_in = rxd_oe_out ? rxd_out : peer_rxd;
	int         fail_count = 0;
	int         samples_checked = 0;
	// system clock, 40 ns
	initial forever #20 clk_sys_in = ~clk_sys_in;
	// baud tick, 320 ns period
	initial forever
	begin
		repeat (4) @(posedge clk_sys_in);
		baud_tick_in <= ~baud_tick_in;
	end
	fmsp_serial_port dut (.clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .rxd_in, .rxd_out, .rxd_oe_out,
		.txd_out, .baud_tick_in, .irq_out);
	fmsp_peer peer (.clk_in(clk_sys_in), .rxd_line_out(peer_rxd), .txd_in(txd_out));
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		{reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'b1};
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_sys_in);
		{reg_addr_in, reg_rd_in} <= {a, 1'b1};
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#3000000;
		fail_count++;
		end_sim;
	end
	// scenarios
	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		for (int i = 1; i < 8; i++)
		begin
			rd(3'(i), d);
			`CHK(d, 8'h00)
		end
		wr(`FMSP_OFS_MASK, 8'h07);
		wr(`FMSP_OFS_CTL, 8'h50);
		fork
			peer.get(128, f);
			wr(`FMSP_OFS_BUF, 8'hA5);
			peer.send(128, {2'b11, 8'h3C, 1'b0});
		join
		`CHK(f, {2'b11, 8'hA5, 1'b0})
		rd(`FMSP_OFS_STAT, d);
		`CHK(d, 8'h03)
		`CHK(irq_out, 1'b1)
		rd(`FMSP_OFS_BUF, d);
		`CHK(d, 8'h3C)
		rd(`FMSP_OFS_CTL, d);
		`CHK(d, 8'h57)
		wr(`FMSP_OFS_STAT, 8'h03);
		`CHK(irq_out, 1'b0)
		peer.send(128, {2'b11, 8'h11, 1'b0});
		peer.send(128, {2'b11, 8'h22, 1'b0});
		rd(`FMSP_OFS_STAT, d);
		`CHK(d, 8'h05)
		rd(`FMSP_OFS_BUF, d);
		`CHK(d, 8'h11)
		wr(`FMSP_OFS_MASK, 8'h00);
		wr(`FMSP_OFS_STAT, 8'h07);
		wr(`FMSP_OFS_CTL, 8'hF8);
		fork
			peer.get(128, f);
			wr(`FMSP_OFS_BUF, 8'h96);
			peer.send(128, {2'b10, 8'h69, 1'b0});
		join
		`CHK(f, {2'b11, 8'h96, 1'b0})
		repeat (16) @(posedge clk_sys_in);
		rd(`FMSP_OFS_STAT, d);
		`CHK(d, 8'h02)
		wr(`FMSP_OFS_STAT, 8'h07);
		peer.send(128, {2'b01, 8'h4B, 1'b0});
		rd(`FMSP_OFS_STAT, d);
		`CHK(d, 8'h01)
		rd(`FMSP_OFS_CTL, d);
		`CHK(d, 8'hFD)
		rd(`FMSP_OFS_BUF, d);
		`CHK(d, 8'h4B)
		wr(`FMSP_OFS_CTL, 8'h80);
		for (int r = 0; r < 2; r++)
		begin
			b = r ? 8'hC3 : 8'h3A;
			wr(`FMSP_OFS_RATE, r ? 8'h01 : 8'h00);
			fork
				peer.get(r ? 32 : 64, f);
				wr(`FMSP_OFS_BUF, b);
			join
			`CHK(f, {2'b10, b, 1'b0})
			repeat (64) @(posedge clk_sys_in);
			rd(`FMSP_OFS_STAT, d);
			`CHK(d[1], 1'b1)
			wr(`FMSP_OFS_STAT, 8'h02);
		end
		wr(`FMSP_OFS_STAT, 8'h07);
		wr(`FMSP_OFS_CTL, 8'h00);
		fork
			wr(`FMSP_OFS_BUF, 8'hB4);
			for (int i = 0; i < 8; i++)
			begin
				@(posedge txd_out);
				d[i] = rxd_out;
			end
		join
		repeat (8) @(posedge clk_sys_in);
		`CHK(d, 8'hB4)
		rd(`FMSP_OFS_STAT, d);
		`CHK(d, 8'h02)
		wr(`FMSP_OFS_STAT, 8'h07);
		fork
			peer.shift_out(8'h5A);
			wr(`FMSP_OFS_CTL, 8'h10);
		join
		repeat (16) @(posedge clk_sys_in);
		rd(`FMSP_OFS_STAT, d);
		`CHK(d, 8'h01)
		`CHK(txd_out, 1'b1)
		rd(`FMSP_OFS_BUF, d);
		`CHK(d, 8'h5A)
		end_sim;
	end
endmodule // tb
